// ==== hdl/nvmac_ctrl.sv ====
/*
  Nonvolatile array access controller: I/O registers, master write enable
  timeout, self-timed write, read fetch, ready interrupt and CPU stall.
  Assumes the I/O bus and global interrupt bit are on core_clk.
*/
`timescale 1ns/10ps
`default_nettype none
`include "nvmac_regs.svh"

// Behaviour
// - Address, data and control registers sit in processor I/O space.
// - Array is 512 bytes addressed linearly by 9 bits, 0 to 511.
// - Address high bits 15..9 and control bits 7..4 read as zero.
// - Address is not reset; software loads it before any access.
// - Data register gives write byte and holds byte fetched by read.
// - Ready interrupt asserted while both enables set and write strobe zero.
// - Master write enable self-clears four cycles after software sets it.
// - Write strobe starts a write only while master write enable is one.
// - Write is self-timed; hardware clears write strobe when done.
// - Setting write strobe without read strobe stalls the processor two cycles.
// - Read strobe fetches byte into data register, then clears itself.
// - Setting read strobe stalls the processor four cycles.
// - Address or data write during a write aborts it.
module nvmac_ctrl #(
  parameter int unsigned WRITE_CYCLES = `NVMAC_WRITE_CYCLES
) (
  // Clock and reset
  input  wire logic                       core_clk,
  input  wire logic                       rst_n,
  // Processor I/O bus
  input  wire nvmac_pkg::nvmac_io_req_type io_req,
  output logic [7:0]                      io_rdata,
  input  wire logic                       global_irq_en,
  output logic                            ready_irq,
  output logic                            cpu_halt,
  // Storage array
  output nvmac_pkg::nvmac_mem_req_type    mem_req,
  input  wire logic [7:0]                 mem_rdata
);

  logic [8:0]  addr_q;
  logic [7:0]  data_q;
  logic        ready_ie_q;
  logic        mwe_q;
  logic        wstrobe_q;
  logic [2:0]  mwe_cnt_q;
  logic [2:0]  halt_cnt_q;
  logic [31:0] wcnt_q;
  logic        rd_pend_q;
  nvmac_pkg::nvmac_state_type state_q;

  logic sel_ctl, sel_data, sel_lo, sel_hi;
  logic start_wr, start_rd, abort_wr;

  assign sel_ctl  = io_req.wr && io_req.addr == `NVMAC_OFF_CONTROL;
  assign sel_data = io_req.wr && io_req.addr == `NVMAC_OFF_DATA;
  assign sel_lo   = io_req.wr && io_req.addr == `NVMAC_OFF_ADDR_LOW;
  assign sel_hi   = io_req.wr && io_req.addr == `NVMAC_OFF_ADDR_HIGH;

  assign start_wr = sel_ctl && io_req.wdata[`NVMAC_BIT_WRITE_STROBE] && mwe_q
                    && state_q == nvmac_pkg::NVMAC_IDLE;
  // Reads are refused while a write runs; the strobe bit is ignored then
  assign start_rd = sel_ctl && io_req.wdata[`NVMAC_BIT_READ_STROBE]
                    && state_q == nvmac_pkg::NVMAC_IDLE;
  assign abort_wr = state_q == nvmac_pkg::NVMAC_WRITE
                    && (sel_data || sel_lo || sel_hi);

  // Address has no reset value
  always_ff @(posedge core_clk) begin
    if (sel_lo) begin
      addr_q[7:0] <= io_req.wdata;
    end
    if (sel_hi) begin
      addr_q[8] <= io_req.wdata[0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      data_q <= `NVMAC_DATA_RESET;
    end else if (rd_pend_q) begin
      data_q <= mem_rdata;
    end else if (sel_data) begin
      data_q <= io_req.wdata;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ready_ie_q <= 1'b0;
    end else if (sel_ctl) begin
      ready_ie_q <= io_req.wdata[`NVMAC_BIT_READY_IE];
    end
  end

  // Master write enable with timeout
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      mwe_q     <= 1'b0;
      mwe_cnt_q <= 3'h0;
    end else if (sel_ctl && io_req.wdata[`NVMAC_BIT_MASTER_WE]) begin
      mwe_q     <= 1'b1;
      mwe_cnt_q <= `NVMAC_MWE_CYCLES - 3'h1;
    end else if (mwe_q) begin
      if (mwe_cnt_q == 3'h0) begin
        mwe_q <= 1'b0;
      end else begin
        mwe_cnt_q <= mwe_cnt_q - 3'h1;
      end
    end
  end

  // Self-timed write
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_q   <= nvmac_pkg::NVMAC_IDLE;
      wstrobe_q <= 1'b0;
      wcnt_q    <= 32'h0;
    end else begin
      case (state_q)
        nvmac_pkg::NVMAC_IDLE: begin
          if (start_wr) begin
            state_q   <= nvmac_pkg::NVMAC_WRITE;
            wstrobe_q <= 1'b1;
            wcnt_q    <= WRITE_CYCLES - 1;
          end
        end
        nvmac_pkg::NVMAC_WRITE: begin
          if (abort_wr || wcnt_q == 32'h0) begin
            state_q   <= nvmac_pkg::NVMAC_IDLE;
            wstrobe_q <= 1'b0;
          end else begin
            wcnt_q <= wcnt_q - 32'h1;
          end
        end
        default: begin
          state_q   <= nvmac_pkg::NVMAC_IDLE;
          wstrobe_q <= 1'b0;
        end
      endcase
    end
  end

  // Read fetch and processor stall
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rd_pend_q  <= 1'b0;
      halt_cnt_q <= 3'h0;
    end else begin
      rd_pend_q <= start_rd;
      if (start_rd) begin
        halt_cnt_q <= `NVMAC_RD_STALL_CYCLES;
      end else if (start_wr) begin
        halt_cnt_q <= `NVMAC_WR_STALL_CYCLES;
      end else if (halt_cnt_q != 3'h0) begin
        halt_cnt_q <= halt_cnt_q - 3'h1;
      end
    end
  end

  assign cpu_halt  = halt_cnt_q != 3'h0;
  assign ready_irq = global_irq_en && ready_ie_q && !wstrobe_q;

  // Array programmed the cycle after the last write cycle; abort leaves it unwritten
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      mem_req <= '0;
    end else begin
      mem_req.addr  <= addr_q;
      mem_req.wdata <= data_q;
      mem_req.we    <= state_q == nvmac_pkg::NVMAC_WRITE && wcnt_q == 32'h0 && !abort_wr;
    end
  end

  always_comb begin
    case (io_req.addr)
      `NVMAC_OFF_CONTROL:   io_rdata = {4'h0, ready_ie_q, mwe_q, wstrobe_q, rd_pend_q};
      `NVMAC_OFF_DATA:      io_rdata = data_q;
      `NVMAC_OFF_ADDR_LOW:  io_rdata = addr_q[7:0];
      `NVMAC_OFF_ADDR_HIGH: io_rdata = {7'h00, addr_q[8]};
      default:              io_rdata = 8'h00;
    endcase
  end

  ready_irq_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    ready_irq == (global_irq_en && ready_ie_q && !wstrobe_q))
    else $error("ready interrupt wrong");

  sequence mwe_set_s;
    sel_ctl && io_req.wdata[`NVMAC_BIT_MASTER_WE];
  endsequence
  mwe_timeout_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    mwe_set_s ##1 !sel_ctl [*4] |=> !mwe_q)
    else $error("master enable did not time out");

  mwe_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    mwe_set_s |=> mwe_q [*4])
    else $error("master enable dropped early");

  wr_gate_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(wstrobe_q) |-> $past(mwe_q))
    else $error("write without master enable");

  wr_stall_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    start_wr && !start_rd |=> cpu_halt [*2] ##1 !cpu_halt)
    else $error("write stall not two cycles");

  rd_stall_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    start_rd |=> cpu_halt [*4] ##1 !cpu_halt)
    else $error("read stall not four cycles");

  rd_fetch_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    start_rd |=> rd_pend_q ##1 (data_q == $past(mem_rdata) && !rd_pend_q))
    else $error("read data not fetched");

  wr_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    state_q == nvmac_pkg::NVMAC_WRITE && wcnt_q != 32'h0 && !abort_wr |=> wstrobe_q)
    else $error("write strobe dropped early");

  wr_abort_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    abort_wr |=> !wstrobe_q && !mem_req.we)
    else $error("write not aborted");

endmodule
`default_nettype wire

// ==== inc/nvmac_pkg.sv ====
/*
  Types of the nonvolatile array access controller.
  Assumes nvmac_regs.svh supplies the numeric constants.
*/
`default_nettype none
package nvmac_pkg;
  typedef enum logic [1:0] {
    NVMAC_IDLE  = 2'b00,
    NVMAC_WRITE = 2'b01
  } nvmac_state_type;

  // I/O bus request from the processor
  typedef struct packed {
    logic [5:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } nvmac_io_req_type;

  // Request to the storage array
  typedef struct packed {
    logic [8:0] addr;
    logic [7:0] wdata;
    logic       we;
  } nvmac_mem_req_type;
endpackage
`default_nettype wire

// ==== inc/nvmac_regs.svh ====
/*
  Register offsets, field positions, reset values and timing counts of the
  nonvolatile array access controller. Assumes a 50 MHz core clock.
*/
`ifndef NVMAC_REGS_SVH
`define NVMAC_REGS_SVH

`define NVMAC_OFF_CONTROL      6'h1c
`define NVMAC_OFF_DATA         6'h1d
`define NVMAC_OFF_ADDR_LOW     6'h1e
`define NVMAC_OFF_ADDR_HIGH    6'h1f

`define NVMAC_BIT_READ_STROBE  0
`define NVMAC_BIT_WRITE_STROBE 1
`define NVMAC_BIT_MASTER_WE    2
`define NVMAC_BIT_READY_IE     3

`define NVMAC_CONTROL_RESET    8'h00
`define NVMAC_DATA_RESET       8'h00

`define NVMAC_MWE_CYCLES       3'h4
`define NVMAC_WR_STALL_CYCLES  3'h2
`define NVMAC_RD_STALL_CYCLES  3'h4
`define NVMAC_WRITE_TIME_US    2500
`define NVMAC_CLK_MHZ          50
`define NVMAC_WRITE_CYCLES     (`NVMAC_WRITE_TIME_US * `NVMAC_CLK_MHZ)

`endif

// ==== testbench/test_nvmac_ctrl.sv ====
/*
  Self-checking bench for nvmac_ctrl: registers, write, read, abort, stall.
  Assumes a shortened write time and an async-read array modelled here.
*/
`timescale 1ns/10ps
`default_nettype none
`include "nvmac_regs.svh"
module test_nvmac_ctrl;
  logic                        core_clk = 0;
  logic                        rst_n    = 0;
  nvmac_pkg::nvmac_io_req_type io_req   = '0;
  logic [7:0]                  io_rdata;
  logic                        global_irq_en = 0;
  logic                        ready_irq;
  logic                        cpu_halt;
  nvmac_pkg::nvmac_mem_req_type mem_req;
  logic [7:0]                  mem_rdata;
  logic                        smp = 0;
  logic [8:0]                  q_rd[$];
  logic [16:0]                 q_wr[$];
  int                          q_h[$];
  int                          n_fail = 0;
  int                          samples_checked = 0;
  int                          hl = 0;
  int                          n;
  logic [8:0]                  a;
  logic [7:0]                  d;
  localparam logic [5:0] CTL = `NVMAC_OFF_CONTROL;
  localparam logic [5:0] DAT = `NVMAC_OFF_DATA;
  always #10 core_clk = ~core_clk;
  // Array content derived from address so reads are predictable
  function automatic logic [7:0] f(logic [8:0] x);
    return x[7:0] ^ {7'h0, x[8]} ^ 8'h3c;
  endfunction
  assign mem_rdata = f(mem_req.addr);
  nvmac_ctrl #(.WRITE_CYCLES(20)) i_dut (
    .core_clk(core_clk), .rst_n(rst_n), .io_req(io_req), .io_rdata(io_rdata),
    .global_irq_en(global_irq_en), .ready_irq(ready_irq), .cpu_halt(cpu_halt),
    .mem_req(mem_req), .mem_rdata(mem_rdata));
  task rep(logic ok, string m);
    samples_checked++;
    if (!ok) begin
      n_fail++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask
  task cmp_reg(logic [8:0] g, logic [8:0] e); rep(g === e, "register or irq"); endtask
  task cmp_wr(logic [16:0] g, logic [16:0] e); rep(g === e, "array write"); endtask
  task cmp_halt(int g, int e); rep(g == e, "stall length"); endtask
  task end_of_test;
    $display("checked %0d failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Writes leave one idle cycle so wr never toggles twice in a step
  task wr(logic [5:0] ad, logic [7:0] v);
    io_req.addr = ad;
    io_req.wdata = v;
    io_req.wr = 1;
    @(posedge core_clk) #1 io_req.wr = 0;
    @(posedge core_clk) #1;
  endtask
  task rd(logic [5:0] ad, logic [8:0] e);
    io_req.addr = ad;
    q_rd.push_back(e);
    smp = 1;
    @(posedge core_clk) #1 smp = 0;
  endtask
  always @(negedge core_clk) begin
    if (smp)
      cmp_reg({ready_irq, io_rdata}, q_rd.pop_front());
    if (mem_req.we === 1'b1)
      cmp_wr({mem_req.addr, mem_req.wdata}, q_wr.pop_front());
    if (cpu_halt === 1'b1)
      hl++;
    else if (hl > 0) begin
      cmp_halt(hl, q_h.pop_front());
      hl = 0;
    end
  end
  initial begin
    #(20 * 2000);
    n_fail++;
    end_of_test;
  end
  initial begin
    void'($urandom(32'hdf346de5));
    a = 9'($urandom);
    d = 8'($urandom);
    repeat (2) @(posedge core_clk);
    #1 rst_n = 1;
    rd(CTL, 9'h000);
    rd(DAT, 9'h000);
    rd(6'h00, 9'h000);
    wr(`NVMAC_OFF_ADDR_HIGH, {7'h7f, a[8]});
    rd(`NVMAC_OFF_ADDR_HIGH, {8'h00, a[8]});
    wr(`NVMAC_OFF_ADDR_LOW, a[7:0]);
    wr(DAT, d);
    wr(CTL, 8'hf2);
    rd(CTL, 9'h000);
    global_irq_en = 1;
    wr(CTL, 8'h0c);
    for (int i = 0; i < 4; i++) rd(CTL, i < 3 ? 9'h10c : 9'h108);
    q_h.push_back(2);
    q_wr.push_back({a, d});
    // Interrupts masked across the enable-then-strobe steps
    global_irq_en = 0;
    wr(CTL, 8'h0c);
    wr(CTL, 8'h0a);
    global_irq_en = 1;
    // Master enable is still in its fourth cycle here
    rd(CTL, 9'h00e);
    wr(CTL, 8'h08);
    rd(CTL, 9'h00a);
    io_req.addr = CTL;
    for (n = 0; n < 40 && io_rdata[1] !== 1'b0; n++) @(posedge core_clk) #1;
    if (n == 40) rep(1'b0, "write never finished");
    rd(CTL, 9'h108);
    q_h.push_back(4);
    wr(CTL, 8'h09);
    rd(DAT, {1'b1, f(a)});
    rd(CTL, 9'h108);
    q_h.push_back(2);
    global_irq_en = 0;
    wr(CTL, 8'h04);
    wr(CTL, 8'h02);
    // Read strobe refused while the write runs
    wr(CTL, 8'h01);
    rd(CTL, 9'h002);
    wr(DAT, ~d);
    rd(CTL, 9'h000);
    repeat (30) @(posedge core_clk) #1;
    rd(DAT, {1'b0, ~d});
    end_of_test;
  end
endmodule
`default_nettype wire
